// *** hdl/scsi_fifo_strobe_ack_sequencer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "seq_defs.svh"

module scsi_fifo_strobe_ack_sequencer
  import seq_pkg::*;
(
  input wire logic sys_clk_in,                   // 125 MHz clock
  input wire logic rst_n_in,                     // Sync reset, active low
  input wire logic req_in,                       // Target REQ
  input wire logic io_dir_in_in,                 // High: bus direction in
  input wire logic fifo_has_data_in,             // FIFO not empty
  input wire logic fifo_half_full_in,            // FIFO at/above half
  input wire logic sync_mode_in,                 // Synchronous enable
  input wire logic offset_nonzero_in,            // Offset count nonzero
  input wire logic [`SEQ_SEL_W-1:0] delay_sel_in, // Delay load value
  input wire logic [`SEQ_DATA_W-1:0] fifo_data_in, // FIFO output
  output logic fifo_strobe_out,                  // FIFO strobe
  output logic ack_out,                          // ACK to target
  output logic [`SEQ_DATA_W-1:0] tx_data_out,    // Transmit register
  output logic tx_valid_out,                     // Transmit reg valid
  output logic read_active_out                   // FIFO read in progress
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  pin_bus_t pins_raw;                      // Pin levels as a bundle
  pin_bus_t meta;                          // First synchroniser stage
  pin_bus_t pins;                          // Second stage, safe to use
  logic req_prev;                          // For REQ edge detection
  logic req_rise;                          // REQ leading edge
  logic write_pending;                     // REQ edge not yet served
  stb_state_t st;                          // Strobe sequencer state
  stb_state_t next_st;                     // Its next value
  logic [`SEQ_STRETCH_W-1:0] stretch;      // Dwell in third stage
  logic write_pulse_stage_a;               // First write stage
  logic write_pulse_stage_b;               // Shared delay stage
  logic write_pulse_stage_c;               // Shared delay stage
  logic async_read_start;                  // Async read start element
  logic sync_read_start;                   // Sync read start element
  logic read_active_strobe;                // Read in progress
  logic next_read_active;                  // Its next value
  logic read_end_state;                    // Read ends this cycle
  logic async_go;                          // Async read may begin
  logic sync_go;                           // Sync read may begin
  logic [`SEQ_SETTLE_W-1:0] settle;        // Flag settling after a read
  logic tx_valid;                          // Transmit reg holds data
  ack_state_t ast;                         // ACK sequencer state
  ack_state_t next_ast;                    // Its next value
  logic ack_done;                          // ACK cycle finished
  logic [`SEQ_MIN_W-1:0] min_cnt;          // Cycles since data load
  logic [`SEQ_MIN_W-1:0] min_need;         // Least cycles for mode
  logic min_done;                          // Least time has passed
  logic tmr_start;                         // Invoke delay timer
  logic [`SEQ_SEL_W-1:0] tmr_sel;          // Timer start value
  logic tmr_done;                          // Timer exit pulse
  logic rx_ack;                            // Receive-side ACK level
  logic next_rx_ack;                       // Its next value

  // Least time for the current mode, in cycles
  function automatic logic [`SEQ_MIN_W-1:0] mode_min(
    input logic sync_en, input logic [`SEQ_SEL_W-1:0] sel);
    if (!sync_en) begin
      return `SEQ_MIN_W'(`SEQ_ASYNC_MIN_CYC);
    end else if (sel >= `SEQ_FAST_LOWEST) begin
      return `SEQ_MIN_W'(`SEQ_FAST_MIN_CYC);
    end else begin
      return `SEQ_MIN_W'(`SEQ_SYNC_MIN_CYC);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser: every outside level passes two flops
  assign pins_raw = '{req: req_in, dir_in: io_dir_in_in,
                      has_data: fifo_has_data_in,
                      half_full: fifo_half_full_in,
                      sync_en: sync_mode_in,
                      offset_nz: offset_nonzero_in,
                      sel: delay_sel_in, data: fifo_data_in};

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      pins <= '0;
      req_prev <= 1'b0;
    end else begin
      meta <= pins_raw;
      pins <= meta;
      req_prev <= pins.req;
    end
  end

  assign req_rise = pins.req && !req_prev;

  // A REQ edge during a busy strobe is kept, set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      write_pending <= 1'b0;
    end else if (req_rise && pins.dir_in) begin
      write_pending <= 1'b1;
    end else if (next_st == STB_STAGE_A) begin
      write_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Strobe sequencer: writes and reads share stages b and c
  // After a read the synchronised not-empty flag is stale for two
  // cycles; a read started on it could pop an already empty FIFO
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      settle <= '0;
    end else if (read_end_state) begin
      settle <= `SEQ_SETTLE_W'(`SEQ_FLAG_SETTLE);
    end else if (settle != '0) begin
      settle <= settle - `SEQ_SETTLE_W'(1);
    end
  end

  assign async_go = !pins.sync_en && pins.has_data && !pins.dir_in
                    && !read_active_strobe
                    && (settle == '0);
  assign sync_go = pins.offset_nz && pins.sync_en && pins.has_data
                   && !pins.dir_in && !read_active_strobe
                   && (settle == '0);

  always_comb begin
    next_st = st;
    case (st)
      STB_IDLE: begin
        // Half-full flag is not looked at: writes never stall here
        if (write_pending && pins.dir_in) begin
          next_st = STB_STAGE_A;
        end else if (async_go || sync_go) begin
          next_st = STB_RSTART;
        end
      end
      STB_STAGE_A: next_st = STB_STAGE_B;
      STB_RSTART: next_st = STB_STAGE_B;
      STB_STAGE_B: next_st = STB_STAGE_C;
      STB_STAGE_C: begin
        if (stretch == `SEQ_STRETCH_W'(`SEQ_C_LAST)) begin
          next_st = read_active_strobe ? STB_RD_END : STB_RECOVER;
        end
      end
      // Wait element: leaves only once the register is free
      STB_RD_END: if (!tx_valid) next_st = STB_IDLE;
      STB_RECOVER: next_st = STB_IDLE;
      default: next_st = STB_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= STB_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Dwell counter for the third stage sets the fixed width
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      stretch <= '0;
    end else if (st == STB_STAGE_C) begin
      stretch <= stretch + `SEQ_STRETCH_W'(1);
    end else begin
      stretch <= '0;
    end
  end

  assign write_pulse_stage_a = (st == STB_STAGE_A);
  assign write_pulse_stage_b = (st == STB_STAGE_B);
  assign write_pulse_stage_c = (st == STB_STAGE_C);
  assign async_read_start = (st == STB_RSTART) && !pins.sync_en;
  assign sync_read_start = (st == STB_RSTART) && pins.sync_en;
  assign read_end_state = (st == STB_RD_END) && !tx_valid;

  // Read-active flag, raised with the start element
  always_comb begin
    next_read_active = read_active_strobe;
    if (st == STB_IDLE && next_st == STB_RSTART) begin
      next_read_active = 1'b1;
    end else if (read_end_state) begin
      next_read_active = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      read_active_strobe <= 1'b0;
    end else begin
      read_active_strobe <= next_read_active;
    end
  end

  // Strobe from next state so it is glitch-free and aligned
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      fifo_strobe_out <= 1'b0;
    end else begin
      fifo_strobe_out <= (next_st == STB_STAGE_A)
        || (next_st == STB_STAGE_B) || (next_st == STB_STAGE_C)
        || next_read_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit register: loaded as the read strobe falls
  // FIFO data are stable while the strobe is high, so the
  // synchronised copy is sound at the trailing edge
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_data_out <= '0;
    end else if (read_end_state) begin
      tx_data_out <= pins.data;
    end
  end

  // Valid flag; the next read waits in its end state meanwhile
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      tx_valid <= 1'b0;
    end else if (read_end_state) begin
      tx_valid <= 1'b1;
    end else if (ack_done) begin
      tx_valid <= 1'b0;
    end
  end

  // Cycles since load, saturating
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      min_cnt <= '0;
    end else if (read_end_state) begin
      min_cnt <= '0;
    end else if (min_cnt != {`SEQ_MIN_W{1'b1}}) begin
      min_cnt <= min_cnt + `SEQ_MIN_W'(1);
    end
  end

  assign min_need = mode_min(pins.sync_en, pins.sel);
  assign min_done = (min_cnt >= min_need);

  ////////////////////////////////////////////////////////////////////////
  // Transmit ACK sequencer
  always_comb begin
    next_ast = ast;
    case (ast)
      ACK_IDLE: if (tx_valid && !pins.dir_in) next_ast = ACK_FILL;
      ACK_FILL: next_ast = ACK_DELAY_ON;
      ACK_DELAY_ON: if (tmr_done) next_ast = ACK_ARM;
      // Never raise ACK before the least time, nor near full
      ACK_ARM: begin
        if (min_done && !pins.half_full) next_ast = ACK_HOLD;
      end
      ACK_HOLD: begin
        if (pins.sync_en) begin
          next_ast = ACK_DELAY_OFF;
        end else if (!pins.req) begin
          next_ast = ACK_IDLE;
        end
      end
      ACK_DELAY_OFF: if (tmr_done) next_ast = ACK_IDLE;
      default: next_ast = ACK_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ast <= ACK_IDLE;
    end else begin
      ast <= next_ast;
    end
  end

  assign ack_done = (ast != ACK_IDLE) && (next_ast == ACK_IDLE);

  // Delay timer: once for async, on and off for sync
  assign tmr_start = (ast == ACK_FILL)
                     || (ast == ACK_HOLD && pins.sync_en);
  assign tmr_sel = pins.sync_en ? pins.sel : `SEQ_ASYNC_LOAD;

  ack_delay_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(tmr_start),
    .sel_in(tmr_sel),
    .done_out(tmr_done),
    .busy_out()
  );

  ////////////////////////////////////////////////////////////////////////
  // Receive side: async REQ returned as ACK, held off near full
  always_comb begin
    next_rx_ack = rx_ack;
    if (!pins.dir_in || pins.sync_en || !pins.req) begin
      next_rx_ack = 1'b0;
    end else if (!pins.half_full) begin
      next_rx_ack = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rx_ack <= 1'b0;
    end else begin
      rx_ack <= next_rx_ack;
    end
  end

  // Output flops
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      tx_valid_out <= 1'b0;
      read_active_out <= 1'b0;
    end else begin
      ack_out <= (next_ast == ACK_HOLD) || (next_ast == ACK_DELAY_OFF)
                 || next_rx_ack;
      tx_valid_out <= tx_valid;
      read_active_out <= read_active_strobe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_write_strobe_width: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) st == STB_STAGE_A |-> fifo_strobe_out [*5]
      ##1 !fifo_strobe_out)
    else $error("write strobe not 40 ns");

  a_write_entry_cause: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(write_pulse_stage_a)
      |-> $past(write_pending && pins.dir_in && st == STB_IDLE))
    else $error("write began without REQ in input direction");

  a_start_one_cycle: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (async_read_start || sync_read_start)
      |=> !(async_read_start || sync_read_start) && write_pulse_stage_b)
    else $error("start element longer than one cycle");

  a_async_read_cond: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(read_active_strobe) && !pins.sync_en
      |-> $past(!pins.dir_in && pins.has_data && !read_active_strobe))
    else $error("async read began without its conditions");

  a_sync_read_cond: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(read_active_strobe) && $past(pins.sync_en)
      |-> $past(pins.offset_nz && pins.has_data && !pins.dir_in))
    else $error("sync read began without offset or data");

  a_read_end_empty: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $fell(read_active_strobe)
      |-> $past(!tx_valid && st == STB_RD_END) && tx_valid)
    else $error("read ended with register still full");

  a_load_on_fall: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $fell(read_active_strobe)
      |-> tx_data_out == $past(pins.data) ##1 !fifo_strobe_out)
    else $error("register not loaded at strobe trailing edge");

  a_ack_least_time: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(ast == ACK_HOLD)
      |-> $past(min_cnt) >= $past(min_need))
    else $error("ACK before the least data time");

  a_ack_half_full: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(ack_out) |-> !$past(pins.half_full))
    else $error("ACK raised while FIFO half full");

  a_sync_delay_twice: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) ast == ACK_HOLD && pins.sync_en
      |=> ast == ACK_DELAY_OFF && ack_out)
    else $error("sync ACK removal not timed");

  a_async_load_val: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) tmr_start && !pins.sync_en
      |-> tmr_sel == `SEQ_ASYNC_LOAD)
    else $error("async delay not loaded with fixed value");

endmodule // scsi_fifo_strobe_ack_sequencer

`default_nettype wire

// *** hdl/seq_defs.svh ***
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH

// Clock period of sys_clk_in in ns (125 MHz)
`define SEQ_PERIOD_NS 8
// Least time to cycles, rounded up, never below one cycle
`define SEQ_CYC(ns) ((((ns) + `SEQ_PERIOD_NS - 1) / `SEQ_PERIOD_NS) > 0 ? \
  (((ns) + `SEQ_PERIOD_NS - 1) / `SEQ_PERIOD_NS) : 1)

// FIFO strobe width
`define SEQ_STROBE_NS 40
`define SEQ_STROBE_CYC `SEQ_CYC(`SEQ_STROBE_NS)
// Last stretch count in the third strobe stage (stages a and b take one)
`define SEQ_C_LAST (`SEQ_STROBE_CYC - 3)

// Least data-to-ACK times per transfer mode
`define SEQ_ASYNC_MIN_NS 60
`define SEQ_FAST_MIN_NS 40
`define SEQ_SYNC_MIN_NS 90
`define SEQ_ASYNC_MIN_CYC `SEQ_CYC(`SEQ_ASYNC_MIN_NS)
`define SEQ_FAST_MIN_CYC `SEQ_CYC(`SEQ_FAST_MIN_NS)
`define SEQ_SYNC_MIN_CYC `SEQ_CYC(`SEQ_SYNC_MIN_NS)

// Delay counter values
`define SEQ_CNT_ZERO 4'h0
`define SEQ_CNT_ONE 4'h1
`define SEQ_CNT_MAX 4'hF
`define SEQ_ASYNC_LOAD 4'hD
`define SEQ_FAST_LOWEST 4'hB

// Widths
`define SEQ_DATA_W 8
`define SEQ_SEL_W 4
`define SEQ_STRETCH_W 3
`define SEQ_MIN_W 4
// Cycles the not-empty flag lags a read strobe through the synchroniser
`define SEQ_FLAG_SETTLE 2
`define SEQ_SETTLE_W 2

`endif

// *** hdl/seq_pkg.sv ***
`include "seq_defs.svh"

package seq_pkg;

  // Outside levels that pass the two-stage synchroniser together
  typedef struct packed {
    logic req;                          // Target request
    logic dir_in;                       // Bus direction: input to initiator
    logic has_data;                     // FIFO not empty
    logic half_full;                    // FIFO at or above half full
    logic sync_en;                      // Synchronous mode enabled
    logic offset_nz;                    // REQ/ACK offset count nonzero
    logic [`SEQ_SEL_W-1:0] sel;         // Delay select pins
    logic [`SEQ_DATA_W-1:0] data;       // FIFO output data
  } pin_bus_t;

  // FIFO strobe sequencer, shared by writes and reads
  typedef enum logic [6:0] {
    STB_IDLE    = 7'h01,
    STB_STAGE_A = 7'h02,
    STB_RSTART  = 7'h04,
    STB_STAGE_B = 7'h08,
    STB_STAGE_C = 7'h10,
    STB_RD_END  = 7'h20,
    STB_RECOVER = 7'h40
  } stb_state_t;

  // Transmit ACK sequencer
  typedef enum logic [5:0] {
    ACK_IDLE      = 6'h01,
    ACK_FILL      = 6'h02,
    ACK_DELAY_ON  = 6'h04,
    ACK_ARM       = 6'h08,
    ACK_HOLD      = 6'h10,
    ACK_DELAY_OFF = 6'h20
  } ack_state_t;

  // Loadable delay timer
  typedef enum logic [4:0] {
    TMR_IDLE  = 5'h01,
    TMR_HOLD  = 5'h02,
    TMR_LOAD  = 5'h04,
    TMR_COUNT = 5'h08,
    TMR_EXIT  = 5'h10
  } tmr_state_t;

endpackage

// *** hdl/ack_delay_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "seq_defs.svh"

module ack_delay_timer
  import seq_pkg::*;
(
  input wire logic sys_clk_in,                 // System clock
  input wire logic rst_n_in,                   // Sync reset, active low
  input wire logic start_in,                   // Invoke pulse
  input wire logic [`SEQ_SEL_W-1:0] sel_in,    // Start value
  output logic done_out,                       // Exit pulse
  output logic busy_out                        // Timer running
);

  tmr_state_t st;                              // Timer state
  logic [`SEQ_SEL_W-1:0] hold;                 // Holding elements
  logic [`SEQ_SEL_W-1:0] cnt;                  // Toggle counter

  // Toggle enable of each bit: all lower bits at one
  function automatic logic [`SEQ_SEL_W-1:0] toggles(
    input logic [`SEQ_SEL_W-1:0] v);
    logic [`SEQ_SEL_W-1:0] t;
    t = {`SEQ_SEL_W{1'b0}};
    t[0] = 1'b1;
    for (int i = 1; i < `SEQ_SEL_W; i++) begin
      t[i] = t[i-1] & v[i-1];
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sequence: idle, capture, load, count to all ones, exit
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= TMR_IDLE;
    end else begin
      case (st)
        TMR_IDLE: if (start_in) st <= TMR_HOLD;
        TMR_HOLD: st <= TMR_LOAD;
        TMR_LOAD: st <= TMR_COUNT;
        // Each start value leaves by the same count path
        TMR_COUNT: if (cnt == `SEQ_CNT_MAX) st <= TMR_EXIT;
        TMR_EXIT: st <= TMR_IDLE;
        default: st <= TMR_IDLE;
      endcase
    end
  end

  // Pins caught when invoked, then moved into the counter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      hold <= `SEQ_CNT_ZERO;
    end else if (st == TMR_IDLE && start_in) begin
      hold <= sel_in;
    end
  end

  // Up-counting toggle counter; higher start gives shorter wait
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt <= `SEQ_CNT_ZERO;
    end else if (st == TMR_LOAD) begin
      cnt <= hold;
    end else if (st == TMR_COUNT && cnt != `SEQ_CNT_MAX) begin
      cnt <= cnt ^ toggles(cnt);
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      done_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      done_out <= (st == TMR_COUNT) && (cnt == `SEQ_CNT_MAX);
      busy_out <= (st != TMR_IDLE) || start_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_timer_exit_max: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(done_out) |-> $past(cnt) == `SEQ_CNT_MAX)
    else $error("timer exit without full count");

  a_timer_load_hold: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) st == TMR_COUNT && $past(st) == TMR_LOAD
      |-> cnt == $past(hold))
    else $error("counter not loaded from holding elements");

endmodule // ack_delay_timer

`default_nettype wire

// *** bench/target_model.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "seq_defs.svh"
// Stand-in for the target and the data FIFO in front of the sequencer
module target_model (
  input wire logic clk_in, // System clock
  input wire logic ack_in, // ACK from sequencer
  input wire logic strobe_in, // FIFO strobe
  input wire logic dir_in_in, // High: bus direction in
  output logic req_out, // REQ to sequencer
  output logic has_data_out, // FIFO not empty
  output logic [`SEQ_DATA_W-1:0] data_out // FIFO head byte
);
  logic [3:0] left = 4'h0; // Bytes left in FIFO
  logic pulse = 1'h0; // Receive REQ, set by the bench
  logic stb_d = 1'h0; // Strobe one cycle back
  initial req_out = 1'h0;
  initial data_out = 8'h00;
  assign has_data_out = (left != 4'h0);
  //////////////////////////////////////////////////////////////////////
  // Sending: REQ asks, drops on ACK; reads pop on strobe trailing edge
  always @(negedge clk_in) begin
    stb_d <= strobe_in;
    req_out <= dir_in_in ? pulse : ~ack_in;
    if (!dir_in_in && stb_d && !strobe_in) begin
      left <= left - 4'h1;
      data_out <= data_out + 8'h01;
    end
  end
endmodule // target_model
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 0, rst_n = 0, dir = 1, hf = 0, sm = 0, onz = 0; // Drives
  logic [3:0] sel = 4'hD; // Delay select
  logic req, hd, stb, ack, tv, ra; // Block pins
  logic [7:0] d, txd; // Data paths
  int errors = 0, num_checks = 0, n; // Tallies
  scsi_fifo_strobe_ack_sequencer dut_u (.sys_clk_in(clk),
    .rst_n_in(rst_n), .req_in(req), .io_dir_in_in(dir),
    .fifo_has_data_in(hd), .fifo_half_full_in(hf), .sync_mode_in(sm),
    .offset_nonzero_in(onz), .delay_sel_in(sel), .fifo_data_in(d),
    .fifo_strobe_out(stb), .ack_out(ack), .tx_data_out(txd),
    .tx_valid_out(tv), .read_active_out(ra));
  target_model tgt_u (.clk_in(clk), .ack_in(ack), .strobe_in(stb),
    .dir_in_in(dir), .req_out(req), .has_data_out(hd), .data_out(d));
  initial forever #4 clk = ~clk;
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Two back-to-back receive bytes, FIFO past half, synchronous mode
  task t_write;
    sm = 1;
    hf = 1;
    repeat (2) begin
      tgt_u.pulse = 1;
      repeat (3) @(negedge clk);
      tgt_u.pulse = 0;
      for (n = 0; stb !== 1'b1 && n < 9; n++) @(negedge clk);
      for (n = 0; stb === 1'b1 && n < 20; n++) @(negedge clk);
      chk("strobe_width", 8'h05, 8'(n));
      chk("ack_in_write", 8'h00, {7'h0, ack});
      repeat (4) @(negedge clk);
    end
  endtask
  // Three asynchronous sends, ACK held off while FIFO is half full
  task t_tx;
    logic seen;
    seen = 0;
    tgt_u.data_out = 8'hA0;
    tgt_u.left = 4'h3;
    sm = 0;
    dir = 0;
    repeat (40) begin
      @(negedge clk);
      seen |= ack;
    end
    chk("ack_held", 8'h00, {7'h0, seen});
    chk("tx_first", 8'hA0, txd);
    chk("tx_valid", 8'h01, {7'h0, tv});
    hf = 0;
    for (n = 0; txd !== 8'hA1 && n < 60; n++) @(negedge clk);
    for (n = 0; ack !== 1'b1 && n < 60; n++) @(negedge clk);
    chk("ack_gap_ok", 8'h01, {7'h0, n >= 8});
    repeat (60) @(negedge clk);
    chk("bytes_left", 8'h00, {4'h0, tgt_u.left});
  endtask
  // Synchronous read waits for a nonzero offset count
  task t_sync;
    tgt_u.left = 4'h2;
    sm = 1;
    repeat (20) @(negedge clk);
    chk("read_no_offset", 8'h00, {7'h0, ra});
    onz = 1;
    for (n = 0; ra !== 1'b1 && n < 20; n++) @(negedge clk);
    chk("read_offset", 8'h01, {7'h0, ra});
    for (n = 0; ack !== 1'b1 && n < 60; n++) @(negedge clk);
    for (n = 0; ack === 1'b1 && n < 60; n++) @(negedge clk);
    chk("sync_ack_high", 8'h01, {7'h0, n >= 5});
    repeat (80) @(negedge clk);
    chk("sync_bytes_left", 8'h00, {4'h0, tgt_u.left});
  endtask
  // Asynchronous receive: REQ returned as ACK only below half full
  task t_rx;
    sm = 0;
    dir = 1;
    hf = 1;
    tgt_u.pulse = 1;
    repeat (8) @(negedge clk);
    chk("rx_ack_held", 8'h00, {7'h0, ack});
    hf = 0;
    repeat (4) @(negedge clk);
    chk("rx_ack_given", 8'h01, {7'h0, ack});
    tgt_u.pulse = 0;
    repeat (6) @(negedge clk);
    chk("rx_ack_gone", 8'h00, {7'h0, ack});
  endtask
  // Hang guard
  initial begin
    #20000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (4) @(negedge clk);
    chk("reset_outs", 8'h00, {4'h0, stb, ack, tv, ra});
    rst_n = 1;
    repeat (2) @(negedge clk);
    t_write;
    t_tx;
    t_sync;
    t_rx;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
